// ---- dv/sld_host_model.sv ----
// Host model that drives the serial write link of the loader.
// Assumes the bench calls its tasks one at a time; the link clock stands low between frames.
`timescale 1ns/1ns
module sld_host_model (
   // Serial write link.
   output logic shiftClk,
   output logic chipEnable_n,
   output logic register_select,
   output logic dataIn,
   input wire logic dataOut
);
   logic [159:0] seen;
   initial begin
      shiftClk = 1'b0;
      chipEnable_n = 1'b1;
      register_select = 1'b0;
      dataIn = 1'b0;
      seen = '0;
   end
   // Sends one frame most significant bit first and records what leaves the chain output.
   task automatic send(input logic rs, input logic [159:0] v);
      int n;
      n = rs ? 8 : 160;
      #3 register_select = rs;
      #10 chipEnable_n = 1'b0;
      #10 register_select = ~rs;
      #50;
      for (int i = n - 1; i >= 0; i--) begin
         dataIn = v[i];
         #40 shiftClk = 1'b1;
         #20 seen = {seen[158:0], dataOut};
         #20 shiftClk = 1'b0;
         dataIn = ~v[i];
      end
      #20 chipEnable_n = 1'b1;
      #200;
   endtask : send
   // Toggles the link clock with chip enable high.
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         dataIn = ~dataIn;
         #40 shiftClk = 1'b1;
         #40 shiftClk = 1'b0;
      end
      #200;
   endtask : idle_clocks
endmodule : sld_host_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the serial LED matrix loader.
// Assumes the loader answers AHB-Lite with zero wait states.
`timescale 1ns/1ns
module tb_top;
   import sld_pkg::*;
   localparam logic [159:0] PA = {32'h1234_5678, 32'h9ABC_DEF0, 32'h0F0F_F0F0, 32'hC3A5_5A3C, 32'h8000_0001};
   localparam logic [159:0] PB = ~PA;
   logic clk, reset_n, hreadyout, hresp, dataOut, shiftClk, chipEnable_n, registerSel, dataIn;
   logic blankIn, oscSelect, oscIn, oscOut, oscOe, refCurrentOn;
   logic [31:0] hrdata, rd, stat;
   logic [159:0] ledDrive;
   sld_ahb_req_t req, ahbIn;
   int miscompares, check_count;
   assign ahbIn = {req[$bits(sld_ahb_req_t)-1:1], hreadyout};
   sld_loader sld_loader_inst (.clk(clk), .reset_n(reset_n), .ahbReq(ahbIn), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .shiftClk(shiftClk), .chipEnable_n(chipEnable_n),
      .register_select(registerSel), .dataIn(dataIn), .dataOut(dataOut), .blank_input(blankIn),
      .oscSelect(oscSelect), .oscIn(oscIn), .oscOut(oscOut), .oscOe(oscOe),
      .refCurrentOn(refCurrentOn), .ledDrive(ledDrive));
   sld_host_model sld_host_model_inst (.shiftClk(shiftClk), .chipEnable_n(chipEnable_n),
      .register_select(registerSel), .dataIn(dataIn), .dataOut(dataOut));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // External display oscillator at 500 kHz.
   initial begin
      oscIn = 1'b0;
      forever begin
         repeat (100) @(posedge clk);
         oscIn <= ~oscIn;
      end
   end
   task automatic chk(input logic [159:0] s, input logic [159:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      @(posedge clk);
      req.hsel <= 1'b1;
      req.haddr <= {24'h00_0000, a};
      req.htrans <= HTRANS_NONSEQ;
      req.hwrite <= w;
      req.hsize <= 3'h2;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      r = hrdata;
      chk(hresp, HRESP_OKAY);
   endtask : ahb
   task automatic st(input logic [6:0] c0, input logic [6:0] c1, input logic s);
      ahb(1'b0, ADDR_STATUS, 32'h0, stat);
      chk(stat & 32'h0001_7F7F, {15'h0, s, 1'b0, c1, 1'b0, c0});
   endtask : st
   task automatic dots(input logic [159:0] v);
      for (int i = 0; i < DOT_WORDS; i++) begin
         ahb(1'b0, ADDR_DOT0 + 8'(4 * i), 32'h0, rd);
         chk(rd, v[32*i+:32]);
      end
   endtask : dots
   task automatic rises(input int n, input int e);
      int c;
      logic p;
      c = 0;
      p = oscOut;
      repeat (n) begin
         @(posedge clk);
         c += (oscOut === 1'b1 && p === 1'b0);
         p = oscOut;
      end
      chk(c, e);
   endtask : rises
   task automatic t_reset();
      chk(refCurrentOn, 1'b0);
      chk(ledDrive, 160'h0);
      st(7'h00, 7'h00, 1'b1);
      chk(oscOut, 1'b0);
   endtask : t_reset
   task automatic t_dots();
      sld_host_model_inst.send(1'b0, PA);
      dots(PA);
      chk(ledDrive, 160'h0);
      st(7'h00, 7'h00, 1'b1);
      chk(stat[ST_SEL], 1'b0);
   endtask : t_dots
   task automatic t_wake();
      sld_host_model_inst.send(1'b1, 160'h40);
      st(7'h40, 7'h00, 1'b0);
      repeat (2) @(posedge clk);
      chk(refCurrentOn, 1'b1);
      chk(ledDrive, PA);
      sld_host_model_inst.send(1'b1, 160'h85);
      st(7'h40, 7'h05, 1'b0);
      chk(stat[ST_SEL], 1'b1);
      chk(sld_host_model_inst.seen[7:0], {7'h40, 1'b1});
   endtask : t_wake
   task automatic t_chain();
      sld_host_model_inst.send(1'b0, PB);
      chk(sld_host_model_inst.seen, {PA[158:0], PB[159]});
      chk(ledDrive, PB);
      sld_host_model_inst.idle_clocks(6);
      dots(PB);
      sld_host_model_inst.send(1'b0, PA);
      chk(sld_host_model_inst.seen, {PB[158:0], PA[159]});
   endtask : t_chain
   task automatic t_blank();
      @(posedge clk);
      blankIn <= 1'b1;
      repeat (5) @(posedge clk);
      chk(ledDrive, 160'h0);
      blankIn <= 1'b0;
      repeat (5) @(posedge clk);
      chk(ledDrive, PA);
      ahb(1'b1, ADDR_CTRL, 32'h1, rd);
      ahb(1'b0, ADDR_CTRL, 32'h0, rd);
      chk(rd, 32'h1);
      chk(ledDrive, 160'h0);
      ahb(1'b1, ADDR_CTRL, 32'h0, rd);
      ahb(1'b0, 8'h3C, 32'h0, rd);
      chk(rd, 32'h0);
      chk(ledDrive, PA);
   endtask : t_blank
   task automatic t_rst_mid();
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      st(7'h00, 7'h00, 1'b1);
      chk(ledDrive, 160'h0);
      dots(PA);
      sld_host_model_inst.send(1'b1, 160'h40);
   endtask : t_rst_mid
   task automatic t_osc();
      logic [31:0] t0;
      chk(oscOe, 1'b1);
      rises(1600, 2);
      oscSelect <= 1'b0;
      repeat (10) @(posedge clk);
      chk({oscOe, oscOut}, 2'h0);
      ahb(1'b0, ADDR_TICKS, 32'h0, t0);
      repeat (4000) @(posedge clk);
      ahb(1'b0, ADDR_TICKS, 32'h0, rd);
      chk((rd - t0) inside {[19:21]}, 1'b1);
      sld_host_model_inst.send(1'b1, 160'h00);
      @(posedge clk);
      oscSelect <= 1'b1;
      repeat (5) @(posedge clk);
      chk(refCurrentOn, 1'b0);
      ahb(1'b0, ADDR_TICKS, 32'h0, t0);
      rises(900, 0);
      ahb(1'b0, ADDR_TICKS, 32'h0, rd);
      chk(rd, t0);
   endtask : t_osc
   task automatic stop_test();
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      #500_000;
      miscompares++;
      stop_test();
   end
   initial begin
      reset_n <= 1'b0;
      req = '0;
      blankIn = 1'b0;
      oscSelect = 1'b1;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_dots();
      t_wake();
      t_chain();
      t_blank();
      t_rst_mid();
      t_osc();
      stop_test();
   end
endmodule : tb_top

// ---- rtl/sld_loader.sv ----
// Serial dot/control loader of a 5x7 LED matrix driver with display oscillator.
// Assumes shiftClk, chipEnable_n, register_select and dataIn come from a host;
// shiftClk may stop while chip enable is high. AHB-Lite master on clk.
//
// Behaviour
// [RULE_01] Reset low clears all control bits
// [RULE_02] Reset leaves dot pattern data untouched
// [RULE_03] Chip enable low: shift data on rise
// [RULE_04] Shifted-out bit drives chain data output
// [RULE_05] Select low dot, high control register
// [RULE_06] Select captured at chip enable fall
// [RULE_07] Host holds chip enable low while shifting
// [RULE_08] Enable high, clock low: transfer data
// [RULE_09] Oscillator select low external, high internal
// [RULE_10] Oscillator pin drives internal or reads external
// [RULE_11] Blank input high turns LEDs off
// [RULE_12] Sleep stops oscillator and reference current
// [RULE_13] External oscillator stays within its range
// [RULE_14] One IC holds 160-bit dot shifter
// [RULE_15] Reset enters sleep, LEDs blanked
// [RULE_16] Control write 8 bits, bit 7 picks word
// [RULE_17] Clock edges with enable high change nothing
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module sld_loader
   import sld_pkg::*;
(
   // System clock and reset.
   input wire logic clk,
   input wire logic reset_n,
   // AHB-Lite slave.
   input sld_pkg::sld_ahb_req_t ahbReq,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Serial write link.
   input wire logic shiftClk,
   input wire logic chipEnable_n,
   input wire logic register_select,
   input wire logic dataIn,
   output logic dataOut,
   // Display pins.
   input wire logic blank_input,
   input wire logic oscSelect,
   input wire logic oscIn,
   output logic oscOut,
   output logic oscOe,
   output logic refCurrentOn,
   output logic [159:0] ledDrive
);
   import sld_pkg::*;

   // Link side: select capture and frame toggle on the chip enable fall.
   logic selLatched;
   logic frameTgl;

   always_ff @(negedge chipEnable_n or negedge reset_n) begin
      if (!reset_n) begin
         selLatched <= 1'h0;
         frameTgl <= 1'h0;
      end else begin
         selLatched <= register_select; // RULE_06
         frameTgl <= ~frameTgl;
      end
   end

   // Link side shifters; the dot shifter has no reset on purpose.
   logic [DOT_BITS-1:0] dotShift;
   logic [CTRL_BITS-1:0] ctrlShift;
   wire shiftDot = !chipEnable_n && !selLatched; // RULE_17
   wire shiftCtrl = !chipEnable_n && selLatched;

   always_ff @(posedge shiftClk) begin
      if (shiftDot) begin
         dotShift <= {dotShift[DOT_BITS-2:0], dataIn}; // RULE_03 RULE_05 RULE_14
      end
   end

   always_ff @(posedge shiftClk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlShift <= CSHIFT_RST; // RULE_01
      end else if (shiftCtrl) begin
         ctrlShift <= {ctrlShift[CTRL_BITS-2:0], dataIn}; // RULE_05 RULE_16
      end
   end

   // The chain output shows the top bit as it stands after each shift, so a cascade adds no extra stage.
   always_ff @(posedge shiftClk or negedge reset_n) begin
      if (!reset_n) begin
         dataOut <= 1'h0;
      end else if (shiftDot) begin
         dataOut <= dotShift[DOT_BITS-2]; // RULE_04 RULE_14
      end else if (shiftCtrl) begin
         dataOut <= ctrlShift[CTRL_BITS-2]; // RULE_04
      end
   end

   // Pin and link levels into the system domain.
   logic [1:0] ceSync;
   logic [1:0] sclkSync;
   logic [1:0] tglSync;
   logic [1:0] selSync;
   logic [1:0] blankSync;
   logic [1:0] oscSelSync;
   logic [1:0] oscInSync;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ceSync <= 2'h3;
         sclkSync <= 2'h0;
         tglSync <= 2'h0;
         selSync <= 2'h0;
         blankSync <= 2'h0;
         oscSelSync <= 2'h0;
         oscInSync <= 2'h0;
      end else begin
         ceSync <= {ceSync[0], chipEnable_n};
         sclkSync <= {sclkSync[0], shiftClk};
         tglSync <= {tglSync[0], frameTgl};
         selSync <= {selSync[0], selLatched};
         blankSync <= {blankSync[0], blank_input};
         oscSelSync <= {oscSelSync[0], oscSelect};
         oscInSync <= {oscInSync[0], oscIn};
      end
   end

   wire ceHigh = ceSync[1];
   wire sclkLow = !sclkSync[1];
   wire frameSel = selSync[1];
   wire blankIn = blankSync[1];
   wire oscInternal = oscSelSync[1];

   // One transfer per frame, once enable is high and the clock low.
   // The shifters are quiet then, so their bits are read directly.
   logic seenTgl;
   wire framePending = tglSync[1] != seenTgl;
   wire latchPulse = ceHigh && sclkLow && framePending;
   wire latchDot = latchPulse && !frameSel;
   wire latchCtrl = latchPulse && frameSel;
   wire ctrlToWord1 = ctrlShift[CTRL_WORD_SEL_BIT];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seenTgl <= 1'h0;
      end else if (latchPulse) begin
         seenTgl <= tglSync[1];
      end
   end

   // Dot latch keeps its contents through reset.
   logic [DOT_BITS-1:0] dotLatch;

   always_ff @(posedge clk) begin
      if (latchDot) begin
         dotLatch <= dotShift; // RULE_08 RULE_02
      end
   end

   // Control words; the word not addressed by bit 7 keeps its value.
   logic [CW_BITS-1:0] ctrlWord0;
   logic [CW_BITS-1:0] ctrlWord1;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlWord0 <= CW_RST; // RULE_01 RULE_15
         ctrlWord1 <= CW_RST; // RULE_01
      end else if (latchCtrl) begin
         if (ctrlToWord1) begin
            ctrlWord1 <= ctrlShift[CW_BITS-1:0]; // RULE_08 RULE_16
         end else begin
            ctrlWord0 <= ctrlShift[CW_BITS-1:0]; // RULE_08 RULE_16
         end
      end
   end

   wire sleep = !ctrlWord0[CW_SLEEP_BIT];

   // Internal display oscillator, held low in sleep.
   logic [OSC_CNT_W-1:0] oscCnt;
   wire oscWrap = oscCnt == OSC_CNT_W'(OSC_HALF_CYCLES - 1);
   wire intOscRun = oscInternal && !sleep;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oscCnt <= '0;
         oscOut <= 1'h0;
      end else if (!intOscRun) begin
         oscCnt <= '0;
         oscOut <= 1'h0; // RULE_12
      end else if (oscWrap) begin
         oscCnt <= '0;
         oscOut <= ~oscOut; // RULE_10
      end else begin
         oscCnt <= oscCnt + 1'b1;
      end
   end

   // Display tick from the selected oscillator source.
   logic oscInPrev;
   wire extRise = oscInSync[1] && !oscInPrev;
   wire intRise = oscWrap && intOscRun && !oscOut;
   wire displayTick = oscInternal ? intRise : extRise; // RULE_09
   logic [31:0] tickCount;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oscInPrev <= 1'h0;
         tickCount <= TICKS_RST;
      end else begin
         oscInPrev <= oscInSync[1];
         if (displayTick && !sleep) begin
            tickCount <= tickCount + 32'h1;
         end
      end
   end

   // Pin drivers and LED gating.
   logic forceBlank;
   wire ledsOff = sleep || blankIn || forceBlank;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         oscOe <= 1'h0;
         refCurrentOn <= 1'h0;
         ledDrive <= '0;
      end else begin
         oscOe <= oscInternal; // RULE_10
         refCurrentOn <= !sleep; // RULE_12
         ledDrive <= ledsOff ? '0 : dotLatch; // RULE_11 RULE_15
      end
   end

   // AHB-Lite slave: zero wait states, read data registered.
   wire addrValid = ahbReq.hsel && ahbReq.hready && (ahbReq.htrans == HTRANS_NONSEQ);
   wire upperZero = ahbReq.haddr[31:8] == 24'h000000;
   wire [7:0] addrLow = ahbReq.haddr[7:0];
   wire [7:0] dotOffset = addrLow - ADDR_DOT0;
   wire dotHit = upperZero && (addrLow >= ADDR_DOT0) && (dotOffset[7:2] < 6'(DOT_WORDS));
   wire [2:0] dotIdx = dotOffset[4:2];

   logic [31:0] statusWord;
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[ST_CW0_LSB +: CW_BITS] = ctrlWord0;
      statusWord[ST_CW1_LSB +: CW_BITS] = ctrlWord1;
      statusWord[ST_SLEEP] = sleep;
      statusWord[ST_OSC_INT] = oscInternal;
      statusWord[ST_BLANK] = blankIn;
      statusWord[ST_SEL] = frameSel;
   end

   wire [31:0] dotWord = dotLatch[32*dotIdx +: 32];

   logic [31:0] readValue;
   always_comb begin
      readValue = 32'h0000_0000;
      if (dotHit) begin
         readValue = dotWord;
      end else if (upperZero) begin
         case (addrLow)
            ADDR_CTRL: readValue = {31'h0, forceBlank};
            ADDR_STATUS: readValue = statusWord;
            ADDR_TICKS: readValue = tickCount;
            default: readValue = 32'h0000_0000;
         endcase
      end
   end

   logic writeQ;
   logic ctrlAddrQ;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         writeQ <= 1'h0;
         ctrlAddrQ <= 1'h0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'h0;
         hresp <= HRESP_OKAY;
      end else begin
         writeQ <= addrValid && ahbReq.hwrite;
         ctrlAddrQ <= upperZero && (addrLow == ADDR_CTRL);
         hreadyout <= 1'h1;
         hresp <= HRESP_OKAY;
         if (addrValid && !ahbReq.hwrite) begin
            hrdata <= readValue;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         forceBlank <= 1'h0;
      end else if (writeQ && ctrlAddrQ) begin
         forceBlank <= ahbReq.hwdata[CTRL_FORCE_BLANK];
      end
   end

   // Checks on the link domain.
   a_idle_edge_quiet: assert property (@(posedge shiftClk) disable iff (!reset_n) // RULE_17
      chipEnable_n |=> ($stable(dotShift) && $stable(ctrlShift)))
      else $error("Shifter moved while chip enable was high.");

   a_dot_shift_in: assert property (@(posedge shiftClk) disable iff (!reset_n) // RULE_03
      shiftDot |=> dotShift[0] == $past(dataIn))
      else $error("Dot shifter did not take the data input.");

   a_chain_out: assert property (@(posedge shiftClk) disable iff (!reset_n) // RULE_04
      shiftDot |=> dataOut === $past(dotShift[DOT_BITS-2]))
      else $error("Chain output is not the bit shifted out.");

   // Checks on the system domain.
   a_reset_clears_ctrl: assert property (@(posedge clk) // RULE_01
      !reset_n |-> (ctrlWord0 == CW_RST && ctrlWord1 == CW_RST && !refCurrentOn))
      else $error("Control words not cleared in reset.");

   a_dot_hold: assert property (@(posedge clk) // RULE_02
      !latchDot |=> dotLatch === $past(dotLatch))
      else $error("Dot latch changed without a dot transfer.");

   a_ctrl_word_pick: assert property (@(posedge clk) disable iff (!reset_n) // RULE_16
      (latchCtrl && !ctrlToWord1) |=>
         (ctrlWord0 == $past(ctrlShift[CW_BITS-1:0]) && $stable(ctrlWord1)))
      else $error("Control word 0 transfer wrong.");

   a_blank_dark: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
      blankIn |=> ledDrive == '0)
      else $error("LEDs lit while blank input high.");

   a_sleep_dark: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
      sleep [*2] |=> (ledDrive == '0 && !refCurrentOn && !oscOut))
      else $error("Sleep left drivers or oscillator running.");

   a_osc_drive: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
      oscInternal |=> oscOe)
      else $error("Oscillator pin not driven with internal source.");

   a_transfer_once: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
      latchPulse |=> !latchPulse)
      else $error("Second transfer without a new frame.");

endmodule : sld_loader

// ---- rtl/sld_pkg.sv ----
// Constants and carrier types for the serial LED matrix loader.
// Assumes a 100 MHz system clock and an AHB-Lite master on it.
package sld_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int INT_OSC_HZ = 125_000;
   localparam int OSC_HALF_CYCLES = CLK_HZ / (2 * INT_OSC_HZ);
   localparam int OSC_CNT_W = 9;
   localparam int DOT_BITS = 160;
   localparam int CTRL_BITS = 8;
   localparam int CW_BITS = 7;
   localparam int CW_SLEEP_BIT = 6;
   localparam int CTRL_WORD_SEL_BIT = 7;
   localparam int DOT_WORDS = 5;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TICKS = 8'h08;
   localparam logic [7:0] ADDR_DOT0 = 8'h10;
   localparam int CTRL_FORCE_BLANK = 0;
   localparam int ST_CW0_LSB = 0;
   localparam int ST_CW1_LSB = 8;
   localparam int ST_SLEEP = 16;
   localparam int ST_OSC_INT = 17;
   localparam int ST_BLANK = 18;
   localparam int ST_SEL = 19;
   localparam logic [CW_BITS-1:0] CW_RST = 7'h00;
   localparam logic [CTRL_BITS-1:0] CSHIFT_RST = 8'h00;
   localparam logic [31:0] TICKS_RST = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } sld_ahb_req_t;
endpackage : sld_pkg
